//--- core/ocs_defines.vh
// constants for the internal oscillator select and start-up block
`ifndef OCS_DEFINES_VH
`define OCS_DEFINES_VH

`define OCS_CLK_PERIOD_NS 50
`define OCS_START_DELAY_NS 10000
`define OCS_START_DELAY_CYC ((`OCS_START_DELAY_NS + `OCS_CLK_PERIOD_NS - 1) / `OCS_CLK_PERIOD_NS)
`define OCS_OST_LAST 11'h3ff

`define OCS_ADDR_CTRL 8'h00
`define OCS_ADDR_TRIM 8'h04

`define OCS_SCS_BIT 0
`define OCS_LTS_BIT 1
`define OCS_HTS_BIT 2
`define OCS_EXTERNAL_CLOCK_ACTIVE_BIT 3
`define OCS_IRCF_LSB 4
`define OCS_IRCF_MSB 6
`define OCS_TRIM_MSB 4

`define OCS_IRCF_RST 3'h6
`define OCS_IRCF_SLOW 3'h0
`define OCS_IRCF_FAST 3'h7
`define OCS_TRIM_RST 5'h00

`define OCS_MODE_LP 3'h0
`define OCS_MODE_XT 3'h1
`define OCS_MODE_HS 3'h2
`define OCS_MODE_EC 3'h3
`define OCS_MODE_INTIO 3'h4
`define OCS_MODE_INT 3'h5
`define OCS_MODE_RCIO 3'h6
`define OCS_MODE_RC 3'h7

`endif

//--- core/ocs_osc_ctrl.v
// internal oscillator trim, frequency select and dual-speed start-up control
`timescale 1ns/100ps
`default_nettype none
`include "ocs_defines.vh"

// Function
// - trim value is a five-bit signed number, zero after reset.
// - trim 01111 fastest, 00000 centre, 10000 slowest, ordered between.
// - trim write shifts fast oscillator within 1 ms; no completion flag.
// - trim never touches the slow oscillator or its timers.
// - slow oscillator is the time base for power-up, watchdog, fail monitor.
// - slow oscillator runs for code 000 internal use or any dependent timer.
// - every reset forces frequency select to 110, 4 MHz.
// - crossing to a stopped oscillator waits a 10 us start-up delay.
// - switch waits current falling edge, holds output low, waits new rising.
// - stable flags follow oscillator run state, updated when a switch completes.
// - switches among 8 MHz to 125 kHz need no start-up delay.
// - software must avoid frequencies invalid for the supply voltage.
// - source select 0 uses configured mode, 1 internal; reset clears it.
// - automatic source changes never alter the source select bit.
// - external-active reads 1 on configured external source, 0 on internal.
// - sleep aborts crystal start-up count and keeps external-active clear.
// - crystal modes count 1024 cycles holding execution unless dual-speed.
// - dual-speed needs enable bit, source select 0 and crystal mode.
// - dual-speed starts after power-on (and power-up timer) and on wake.
// - during dual-speed, code runs internally while 1024 cycles count.
// - on expiry wait internal fall, set active, hold low, wait external fall.
// - codes 000 to 111 select 31k,125k,250k,500k,1M,2M,4M,8M.
// - fast oscillator runs for nonzero code internal use or dual-speed.
// - control bit 0 source select, bit 1 slow stable, bit 2 fast stable.
module ocs_osc_ctrl (
	input wire clk_sys,
	input wire rst_n,
	input wire ce,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire fast_osc_pin,
	input wire slow_osc_pin,
	input wire ext_osc_pin,
	input wire [2:0] cfg_osc_mode,
	input wire cfg_dual_speed_start_enable,
	input wire cfg_powerup_timer_en,
	input wire cfg_watchdog_en,
	input wire cfg_clock_fail_monitor_en,
	input wire powerup_timer_done,
	input wire sleep_exec,
	input wire wake_event,
	output reg fast_osc_enable,
	output reg slow_osc_enable,
	output reg [4:0] trim_value,
	output reg slow_timebase_tick,
	output reg divided_clock_output,
	output reg sysclk_from_external,
	output reg cpu_hold
);

localparam ST_BOOT = 3'h0;
localparam ST_RUN = 3'h1;
localparam ST_OST = 3'h2;
localparam ST_INT_FALL = 3'h3;
localparam ST_EXT_FALL = 3'h4;
localparam ST_SLEEP = 3'h5;

localparam FS_RUN = 2'h0;
localparam FS_DELAY = 2'h1;
localparam FS_FALL = 2'h2;
localparam FS_RISE = 2'h3;

localparam [31:0] START_DELAY_LAST = `OCS_START_DELAY_CYC - 1;

wire [2:0] pin_raw, pin_lvl;
wire fast_lvl, slow_lvl, ext_lvl;

assign pin_raw = {ext_osc_pin, slow_osc_pin, fast_osc_pin};
assign fast_lvl = pin_lvl[0];
assign slow_lvl = pin_lvl[1];
assign ext_lvl = pin_lvl[2];

genvar gi;
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
		ocs_pin_sync u_sync (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.ce(ce),
			.pin(pin_raw[gi]),
			.level(pin_lvl[gi])
		);
	end
endgenerate

reg [2:0] internal_freq_select;
reg sysclk_source_select;
reg external_clock_active;
reg fast_osc_stable, slow_osc_stable;
reg [2:0] cur_sel, pend_sel;
reg [1:0] fs;
reg [7:0] delay_cnt;
reg [2:0] st;
reg [10:0] ost_cnt;
reg ost_ok;
reg [5:0] post;
reg fast_q, slow_q, ext_q, int_q, new_q;

// postscaler tap for a frequency code; 000 is the slow oscillator itself
function sel_lvl;
	input [2:0] s;
	input sl;
	input fl;
	input [5:0] p;
	sel_lvl = (s == `OCS_IRCF_SLOW) ? sl : (s == `OCS_IRCF_FAST) ? fl : p[3'h6 - s];
endfunction

wire int_lvl, new_lvl, fast_rise, int_fall, new_rise, ext_rise, ext_fall;
wire is_crystal, is_internal_cfg, dual_speed, cross_osc, target_stopped;
wire next_fast_en, next_slow_en, hold_low, int_run, slow_after;

assign int_lvl = sel_lvl(cur_sel, slow_lvl, fast_lvl, post);
assign new_lvl = sel_lvl(pend_sel, slow_lvl, fast_lvl, post);
assign fast_rise = fast_lvl & ~fast_q;
assign int_fall = int_q & ~int_lvl;
assign new_rise = new_lvl & ~new_q;
assign ext_rise = ext_lvl & ~ext_q;
assign ext_fall = ext_q & ~ext_lvl;
assign is_crystal = (cfg_osc_mode == `OCS_MODE_LP) || (cfg_osc_mode == `OCS_MODE_XT) ||
	(cfg_osc_mode == `OCS_MODE_HS);
assign is_internal_cfg = (cfg_osc_mode == `OCS_MODE_INTIO) ||
	(cfg_osc_mode == `OCS_MODE_INT);
assign dual_speed = cfg_dual_speed_start_enable & ~sysclk_source_select & is_crystal;
// the old clock keeps its oscillator alive until the switch has handed over
assign next_slow_en = ((sysclk_source_select | cfg_dual_speed_start_enable) &
	((internal_freq_select == `OCS_IRCF_SLOW) | (cur_sel == `OCS_IRCF_SLOW))) |
	cfg_powerup_timer_en | cfg_watchdog_en | cfg_clock_fail_monitor_en;
assign next_fast_en = (sysclk_source_select | cfg_dual_speed_start_enable) &
	((internal_freq_select != `OCS_IRCF_SLOW) | (cur_sel != `OCS_IRCF_SLOW));
assign cross_osc = (internal_freq_select == `OCS_IRCF_SLOW) != (cur_sel == `OCS_IRCF_SLOW);
assign target_stopped = (internal_freq_select == `OCS_IRCF_SLOW) ? ~slow_osc_enable :
	~fast_osc_enable;
assign hold_low = (fs == FS_RISE) || (st == ST_EXT_FALL);
// a stopped tap has no edge to wait for, so a non-crystal handover must not hang
assign int_run = (cur_sel == `OCS_IRCF_SLOW) ? slow_osc_enable : fast_osc_enable;
assign slow_after = (pend_sel == `OCS_IRCF_SLOW) | cfg_powerup_timer_en | cfg_watchdog_en |
	cfg_clock_fail_monitor_en;

wire bus_req, wr_ctrl, wr_trim;

assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr_ctrl = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OCS_ADDR_CTRL);
assign wr_trim = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OCS_ADDR_TRIM);

// single-wait-state slave; unmapped addresses answer with zero and ignore writes
always @(posedge clk_sys) begin
	if (!rst_n) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0;
		internal_freq_select <= `OCS_IRCF_RST;
		sysclk_source_select <= 1'b0;
		trim_value <= `OCS_TRIM_RST;
	end else if (ce) begin
		wb_ack_o <= bus_req;
		wb_dat_o <= 32'h0;
		if (bus_req && !wb_we_i) begin
			if (wb_adr_i == `OCS_ADDR_CTRL) begin
				wb_dat_o[`OCS_IRCF_MSB:`OCS_IRCF_LSB] <= internal_freq_select;
				wb_dat_o[`OCS_EXTERNAL_CLOCK_ACTIVE_BIT] <= external_clock_active;
				wb_dat_o[`OCS_HTS_BIT] <= fast_osc_stable;
				wb_dat_o[`OCS_LTS_BIT] <= slow_osc_stable;
				wb_dat_o[`OCS_SCS_BIT] <= sysclk_source_select;
			end else if (wb_adr_i == `OCS_ADDR_TRIM) begin
				wb_dat_o[`OCS_TRIM_MSB:0] <= trim_value;
			end
		end
		if (wr_ctrl) begin
			// no voltage check here: picking a legal frequency is up to software
			internal_freq_select <= wb_dat_i[`OCS_IRCF_MSB:`OCS_IRCF_LSB];
			sysclk_source_select <= wb_dat_i[`OCS_SCS_BIT];
		end
		// trim goes straight to the analog tuner, which settles on its own
		if (wr_trim) begin
			trim_value <= wb_dat_i[`OCS_TRIM_MSB:0];
		end
	end
end

// oscillator enables, edge history and the slow time base
always @(posedge clk_sys) begin
	if (!rst_n) begin
		fast_osc_enable <= 1'b0;
		slow_osc_enable <= 1'b0;
		fast_q <= 1'b0;
		slow_q <= 1'b0;
		ext_q <= 1'b0;
		int_q <= 1'b0;
		new_q <= 1'b0;
		post <= 6'h00;
		slow_timebase_tick <= 1'b0;
	end else if (ce) begin
		fast_osc_enable <= next_fast_en;
		slow_osc_enable <= next_slow_en;
		fast_q <= fast_lvl;
		slow_q <= slow_lvl;
		ext_q <= ext_lvl;
		int_q <= int_lvl;
		new_q <= new_lvl;
		if (fast_rise) begin
			post <= post + 6'h01;
		end
		// trim has no path into this tick, so dependent timers keep their rate
		slow_timebase_tick <= slow_lvl & ~slow_q & slow_osc_enable;
	end
end

// internal frequency switch
always @(posedge clk_sys) begin
	if (!rst_n) begin
		cur_sel <= `OCS_IRCF_RST;
		pend_sel <= `OCS_IRCF_RST;
		fs <= FS_RUN;
		delay_cnt <= 8'h00;
		fast_osc_stable <= 1'b0;
		slow_osc_stable <= 1'b0;
	end else if (ce) begin
		case (fs)
			FS_RUN: begin
				if (internal_freq_select != cur_sel) begin
					pend_sel <= internal_freq_select;
					delay_cnt <= 8'h00;
					if (cross_osc && target_stopped) begin
						fs <= FS_DELAY;
					end else begin
						fs <= FS_FALL;
					end
				end
			end
			FS_DELAY: begin
				if (delay_cnt == START_DELAY_LAST[7:0]) begin
					fs <= FS_FALL;
				end else begin
					delay_cnt <= delay_cnt + 8'h01;
				end
			end
			FS_FALL: begin
				if (int_fall) begin
					fs <= FS_RISE;
				end
			end
			default: begin
				if (new_rise) begin
					cur_sel <= pend_sel;
					fast_osc_stable <= fast_osc_enable & (pend_sel != `OCS_IRCF_SLOW);
					slow_osc_stable <= slow_osc_enable & slow_after;
					fs <= FS_RUN;
				end
			end
		endcase
	end
end

// system source selection and crystal start-up
always @(posedge clk_sys) begin
	if (!rst_n) begin
		st <= ST_BOOT;
		ost_cnt <= 11'h000;
		ost_ok <= 1'b0;
		external_clock_active <= 1'b0;
		sysclk_from_external <= 1'b0;
		cpu_hold <= 1'b0;
	end else if (ce) begin
		// source select itself is only written by software
		if (sleep_exec) begin
			st <= ST_SLEEP;
			ost_cnt <= 11'h000;
			ost_ok <= 1'b0;
			external_clock_active <= 1'b0;
			sysclk_from_external <= 1'b0;
			cpu_hold <= 1'b0;
		end else begin
			case (st)
				ST_BOOT: begin
					if (!cfg_powerup_timer_en || powerup_timer_done) begin
						st <= ST_RUN;
					end
				end
				ST_SLEEP: begin
					if (wake_event) begin
						st <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (sysclk_source_select || is_internal_cfg) begin
						sysclk_from_external <= 1'b0;
						external_clock_active <= 1'b0;
					end else if (!sysclk_from_external) begin
						if (is_crystal && !ost_ok) begin
							st <= ST_OST;
							ost_cnt <= 11'h000;
							cpu_hold <= ~dual_speed;
						end else begin
							st <= ST_INT_FALL;
						end
					end
				end
				ST_OST: begin
					if (sysclk_source_select) begin
						st <= ST_RUN;
						cpu_hold <= 1'b0;
					end else if (ext_rise) begin
						if (ost_cnt == `OCS_OST_LAST) begin
							ost_ok <= 1'b1;
							if (dual_speed) begin
								st <= ST_INT_FALL;
							end else begin
								external_clock_active <= 1'b1;
								sysclk_from_external <= 1'b1;
								cpu_hold <= 1'b0;
								st <= ST_RUN;
							end
						end else begin
							ost_cnt <= ost_cnt + 11'h001;
						end
					end
				end
				ST_INT_FALL: begin
					if (int_fall || !int_run) begin
						external_clock_active <= 1'b1;
						st <= ST_EXT_FALL;
					end
				end
				default: begin
					if (ext_fall) begin
						sysclk_from_external <= 1'b1;
						st <= ST_RUN;
					end
				end
			endcase
		end
	end
end

// clock output follows the connected source, low from the old source's falling edge until the new source takes over
always @(posedge clk_sys) begin
	if (!rst_n) begin
		divided_clock_output <= 1'b0;
	end else if (ce) begin
		if (hold_low) begin
			divided_clock_output <= 1'b0;
		end else if (sysclk_from_external) begin
			divided_clock_output <= ext_lvl;
		end else begin
			divided_clock_output <= int_lvl;
		end
	end
end

endmodule

`default_nettype wire

//--- core/ocs_pin_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module ocs_pin_sync (
	input wire clk_sys,
	input wire rst_n,
	input wire ce,
	input wire pin,
	output reg level
);

reg s1;
reg s2;
reg s3;

// s1 feeds only s2; the level moves once s2 and s3 agree
always @(posedge clk_sys) begin
	if (!rst_n) begin
		s1 <= 1'b0;
		s2 <= 1'b0;
		s3 <= 1'b0;
		level <= 1'b0;
	end else if (ce) begin
		s1 <= pin;
		s2 <= s1;
		s3 <= s2;
		if (s2 == s3) begin
			level <= s3;
		end
	end
end

endmodule

`default_nettype wire

//--- sim/ocs_osc_ctrl_sva.sv
// port assertions for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
module ocs_osc_ctrl_chk (
	input wire clk_sys,
	input wire rst_n,
	input wire ce,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire [2:0] cfg_osc_mode,
	input wire cfg_dual_speed_start_enable,
	input wire cfg_watchdog_en,
	input wire sleep_exec,
	input wire slow_osc_enable,
	input wire [4:0] trim_value,
	input wire slow_timebase_tick,
	input wire sysclk_from_external,
	input wire cpu_hold
);
	wire [4:0] wr_trim = wb_dat_i[4:0];
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	wire trim_acc = req && wb_adr_i == 8'h04;
	wire bad_acc = req && wb_adr_i != 8'h00 && wb_adr_i != 8'h04;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	ack_pulse_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse");
	trim_rst_a: assert property ($rose(rst_n) |-> trim_value == 5'h00)
		else $error("trim not zero after reset");
	trim_write_a: assert property (trim_acc && wb_we_i && wb_sel_i[0] |=> trim_value == $past(wr_trim))
		else $error("trim write lost");
	trim_hold_a: assert property (!(trim_acc && wb_we_i) |=> $stable(trim_value))
		else $error("trim moved without write");
	trim_read_a: assert property (trim_acc && !wb_we_i |=> wb_dat_o == {27'h0, trim_value})
		else $error("trim read data wrong");
	bad_read_a: assert property (bad_acc && !wb_we_i |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	hold_mode_a: assert property (cpu_hold |-> cfg_osc_mode <= 3'h2 &&
		!cfg_dual_speed_start_enable && !sysclk_from_external)
		else $error("hold outside crystal start");
	sleep_abort_a: assert property (sleep_exec |=> !sysclk_from_external)
		else $error("external still active after sleep");
	slow_run_a: assert property ($past(cfg_watchdog_en) && $past(rst_n) |-> slow_osc_enable)
		else $error("slow osc off with watchdog");
	tick_pulse_a: assert property (slow_timebase_tick |-> slow_osc_enable ##1 !slow_timebase_tick)
		else $error("bad slow tick");
endmodule
bind ocs_osc_ctrl ocs_osc_ctrl_chk i_chk (.*);
`default_nettype wire

//--- sim/ocs_osc_model.sv
// oscillator and crystal model for the clock control block
`timescale 1ns/100ps
`default_nettype none
module ocs_osc_model #(
	parameter int FAST_HALF = 100,
	parameter int SLOW_HALF = 400,
	parameter int EXT_HALF = 200
) (
	input wire logic fast_en,
	input wire logic slow_en,
	output logic fast_pin,
	output logic slow_pin,
	output logic ext_pin
);
	// a stopped oscillator sits low, so the block only sees edges it asked for
	initial begin
		fast_pin = 1'b0;
		forever #(FAST_HALF) fast_pin = fast_en ? !fast_pin : 1'b0;
	end
	// slow source has no trim input at all, its timing never shifts
	initial begin
		slow_pin = 1'b0;
		forever #(SLOW_HALF) slow_pin = slow_en ? !slow_pin : 1'b0;
	end
	// crystal keeps swinging through sleep; the block must recount anyway
	initial begin
		ext_pin = 1'b0;
		forever #(EXT_HALF) ext_pin = !ext_pin;
	end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// register and start-up tests for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, slp = 0, wake = 0, dual = 0, wdt = 0;
	logic powerup_timer = 0, pdone = 1;
	logic [7:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] dat = 0, q;
	logic [2:0] mode = 3'h5;
	wire [31:0] rdat;
	wire [4:0] trim;
	wire ack, fen, sen, fpin, spin, xpin, tick, dco, ext, hold;
	int n_fail = 0, checks_done = 0;
	initial forever #25 clk_sys = !clk_sys;
	ocs_osc_model i_osc (.fast_en(fen), .slow_en(sen), .fast_pin(fpin), .slow_pin(spin),
		.ext_pin(xpin));
	ocs_osc_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .fast_osc_pin(fpin), .slow_osc_pin(spin),
		.ext_osc_pin(xpin), .cfg_osc_mode(mode), .cfg_dual_speed_start_enable(dual),
		.cfg_powerup_timer_en(powerup_timer), .cfg_watchdog_en(wdt), .cfg_clock_fail_monitor_en(1'b0),
		.powerup_timer_done(pdone), .sleep_exec(slp), .wake_event(wake),
		.fast_osc_enable(fen), .slow_osc_enable(sen), .trim_value(trim),
		.slow_timebase_tick(tick), .divided_clock_output(dco),
		.sysclk_from_external(ext), .cpu_hold(hold));
	task final_report;
		$display("checks=%0d mismatches=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge clk_sys);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		sel <= s;
		do @(posedge clk_sys); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		wb(0, a, 8'h00, 4'h1);
		chk(q, {24'h0, e});
	endtask
	task rst(input logic [2:0] m, input logic d, input logic w);
		rst_n <= 0;
		mode <= m;
		dual <= d;
		wdt <= w;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1;
	endtask
	task wait_ext(input logic v);
		int k;
		k = 0;
		while (ext !== v && k < 20000) begin
			@(posedge clk_sys);
			k++;
		end
		chk(ext, v);
	endtask
	task pulse_sleep(input logic wk);
		@(posedge clk_sys);
		if (wk) wake <= 1; else slp <= 1;
		@(posedge clk_sys);
		wake <= 0;
		slp <= 0;
		repeat (20) @(posedge clk_sys);
		chk(ext, 0);
	endtask
	task dco_live;
		int n;
		logic p;
		n = 0;
		p = dco;
		repeat (16) begin
			@(posedge clk_sys);
			if (dco !== p) n++;
			p = dco;
		end
		chk(n > 0, 1);
	endtask
	initial begin
		#4000000;
		n_fail++;
		final_report;
	end
	initial begin
		rst(3'h5, 0, 0);
		rd(8'h00, 8'h60);
		rd(8'h04, 8'h00);
		wb(1, 8'h04, 8'h0f, 4'h1);
		rd(8'h04, 8'h0f);
		wb(1, 8'h04, 8'hf0, 4'h1);
		rd(8'h04, 8'h10);
		wb(1, 8'h04, 8'h01, 4'h0);
		wb(1, 8'h0c, 8'h55, 4'h1);
		rd(8'h0c, 8'h00);
		rd(8'h04, 8'h10);
		chk(trim, 5'h10);
		// software stays on settings valid for the supply
		wb(1, 8'h00, 8'h61, 4'h1);
		wb(1, 8'h00, 8'h7f, 4'h1);
		repeat (300) @(posedge clk_sys);
		rd(8'h00, 8'h75);
		wb(1, 8'h00, 8'h01, 4'h1);
		repeat (100) @(posedge clk_sys);
		rd(8'h00, 8'h05);
		repeat (500) @(posedge clk_sys);
		rd(8'h00, 8'h03);
		chk({fen, sen}, 2'b01);
		rst(3'h1, 0, 0);
		repeat (50) @(posedge clk_sys);
		chk({hold, ext}, 2'b10);
		wait_ext(1);
		chk(hold, 0);
		rd(8'h00, 8'h68);
		powerup_timer <= 1;
		pdone <= 0;
		rst(3'h3, 0, 0);
		repeat (50) @(posedge clk_sys);
		chk({ext, hold, sen}, 3'b001);
		pdone <= 1;
		wait_ext(1);
		chk(hold, 0);
		rst(3'h2, 1, 1);
		repeat (50) @(posedge clk_sys);
		chk({hold, ext, sen}, 3'b001);
		wait_ext(1);
		dco_live;
		rd(8'h00, 8'h68);
		pulse_sleep(0);
		pulse_sleep(1);
		wait_ext(1);
		wb(1, 8'h00, 8'h61, 4'h1);
		repeat (5) @(posedge clk_sys);
		chk(ext, 0);
		final_report;
	end
endmodule
`default_nettype wire
